// [inc/motor_pwm_defines.vh]
`ifndef MOTOR_PWM_DEFINES_VH
`define MOTOR_PWM_DEFINES_VH

// Register addresses
`define ADDR_CTL_A 12'hf20
`define ADDR_CTL_B 12'hf21
`define ADDR_DEADBAND 12'hf22
`define ADDR_MIN_PULSE 12'hf23
`define ADDR_STATUS 12'hf25
`define ADDR_OFF_SELECT 12'hf27
`define ADDR_DUTY_BASE 12'hf30
`define ADDR_PERIOD 12'hf38
`define ADDR_COUNT_SOURCE 12'hf39

// Duty registers sit at base plus 0..5
`define DUTY_COUNT 3'h6

// Control A fields
`define CTL_A_OFF_BIT 7
`define CTL_A_SEL_BIT 6
`define CTL_A_ALIGN_BIT 5
`define CTL_A_TRIG_BIT 3
`define CTL_A_READY_BIT 1
`define CTL_A_EN_BIT 0
`define CTL_A_WMASK 8'heb

// Control B fields
`define CTL_B_RATE_HI 7
`define CTL_B_RATE_LO 6
`define CTL_B_INDEP_BIT 5
`define CTL_B_POL_HI 4
`define CTL_B_POL_LO 2
`define CTL_B_CLOCK_DIVIDER_HI 1
`define CTL_B_CLOCK_DIVIDER_LO 0

// Status fields
`define STATUS_RELOAD_BIT 7

// Reset values
`define RST_CTL_A 8'h00
`define RST_CTL_B 8'h00
`define RST_DEADBAND 8'h01
`define RST_MIN_PULSE 8'h00
`define RST_OFF_SELECT 6'h00
`define RST_PERIOD 8'hff
`define RST_DUTY 8'h00

`endif

// [design/motor_pwm_control_regs.v]
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "motor_pwm_defines.vh"

// Contract
// R1 - Outputs-off clear forces off-state immediately
// R2 - Outputs-off set restores control at reload
// R3 - Selective-off forces selected outputs off
// R4 - Alignment bit picks edge or center
// R5 - Converter trigger pulses only when enabled
// R6 - Software writes zero to reserved bits
// R7 - Ready clear blocks working register copy
// R8 - Ready set copies holding values at reload
// R9 - Enable clear stops counter, outputs off
// R10 - Enable set runs modulator, drives outputs
// R11 - Reload rate buffered, applied at period end
// R12 - Reload every 1, 2, 4, 8 periods
// R13 - Independent bit selects pairs or six channels
// R14 - Polarity bit inverts its channel pair
// R15 - Prescaler divides input by 1,2,4,8
// R16 - Prescaler buffered, applied at reload event
// R17 - Deadband holds both pair outputs deasserted
// R18 - Deadband and minimum width locked while enabled
// R19 - Minimum pulse width in modulator cycles
// R20 - Off-select bit holds output in off-state
// R21 - Reload flag latches, write one clears
// R22 - Deadband in ticks, short pulses suppressed
module motor_pwm_control_regs (
  input wire clk_sys,
  input wire reset_n,
  input wire [11:0] addr,
  input wire [7:0] wdata,
  input wire wr_strobe,
  input wire rd_strobe,
  output reg [7:0] rdata,
  input wire external_count_input,
  output reg [5:0] pwm_out,
  output reg pwm_out_en,
  output reg converter_trigger
);

  ////////////////////////////////////////////////////////////////////////////
  // Software visible state

  reg [7:0] ctl_a;
  reg [7:0] ctl_b;
  reg [7:0] deadband_count;
  reg [7:0] min_pulse_width;
  reg [5:0] output_off_select;
  reg count_source;
  reg [7:0] period_hold;
  reg [7:0] duty_hold [0:5];
  reg reload_flag;

  // Working copies used by the counter and comparators
  reg [7:0] period_work;
  reg [7:0] duty_work [0:5];
  reg [1:0] clock_divider_work;
  reg [1:0] rate_work;

  // Counter state
  reg [2:0] pre_cnt;
  reg [2:0] rate_cnt;
  reg [7:0] cnt;
  reg count_up;
  reg mod_ctl;
  reg ext_s1;
  reg ext_s2;
  reg ext_s3;

  reg [7:0] next_rdata;
  wire [5:0] next_out;
  integer i;
  integer j;

  // Control field aliases
  wire outputs_off_ctl = ctl_a[`CTL_A_OFF_BIT];
  wire selective_off_ctl = ctl_a[`CTL_A_SEL_BIT];
  wire align = ctl_a[`CTL_A_ALIGN_BIT];
  wire converter_trigger_en = ctl_a[`CTL_A_TRIG_BIT];
  wire ready = ctl_a[`CTL_A_READY_BIT];
  wire modulator_enable = ctl_a[`CTL_A_EN_BIT];
  wire [1:0] reload_rate = ctl_b[`CTL_B_RATE_HI:`CTL_B_RATE_LO];
  wire independent_channels = ctl_b[`CTL_B_INDEP_BIT];
  wire [2:0] pair_invert = ctl_b[`CTL_B_POL_HI:`CTL_B_POL_LO];
  wire [1:0] clock_divider = ctl_b[`CTL_B_CLOCK_DIVIDER_HI:`CTL_B_CLOCK_DIVIDER_LO];

  // Address decode
  wire [11:0] duty_base = `ADDR_DUTY_BASE;
  wire duty_hit = (addr[11:3] == duty_base[11:3]) && (addr[2:0] < `DUTY_COUNT);
  wire wr_ctl_a = wr_strobe && (addr == `ADDR_CTL_A);
  wire wr_ctl_b = wr_strobe && (addr == `ADDR_CTL_B);
  wire wr_db = wr_strobe && (addr == `ADDR_DEADBAND);
  wire wr_mpw = wr_strobe && (addr == `ADDR_MIN_PULSE);
  wire wr_status = wr_strobe && (addr == `ADDR_STATUS);
  wire wr_off = wr_strobe && (addr == `ADDR_OFF_SELECT);
  wire wr_period = wr_strobe && (addr == `ADDR_PERIOD);
  wire wr_source = wr_strobe && (addr == `ADDR_COUNT_SOURCE);
  wire wr_duty = wr_strobe && duty_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Timing chain

  // Divider end values 0, 1, 3 or 7: cycles of 1, 2, 4 or 8 counts
  wire [2:0] pre_max = {&clock_divider_work, clock_divider_work[1], |clock_divider_work}; // R15
  wire [2:0] rate_max = {&rate_work, rate_work[1], |rate_work}; // R12

  // Rising edge of the synchronised external count input
  wire ext_rise = ext_s2 && !ext_s3;
  wire base_tick = count_source ? ext_rise : 1'b1;
  wire tick = modulator_enable && base_tick && (pre_cnt == pre_max); // R15

  // End of a period in either alignment
  wire edge_wrap = ({1'b0, cnt} + 9'h001) >= {1'b0, period_work};
  wire center_end = (period_work == 8'h00) || (!count_up && (cnt <= 8'h01));
  wire period_end = tick && (align ? center_end : edge_wrap); // R4
  wire reload = period_end && (rate_cnt >= rate_max); // R12

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  // Holding registers and control bits
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctl_a <= `RST_CTL_A;
      ctl_b <= `RST_CTL_B;
      deadband_count <= `RST_DEADBAND; // R17
      min_pulse_width <= `RST_MIN_PULSE; // R19
      output_off_select <= `RST_OFF_SELECT;
      count_source <= 1'b0;
      period_hold <= `RST_PERIOD;
      for (i = 0; i < 6; i = i + 1) begin
        duty_hold[i] <= `RST_DUTY;
      end
    end else begin
      if (wr_ctl_a) begin
        // Reserved positions are dropped and read back as zero
        ctl_a <= wdata & `CTL_A_WMASK; // R6
      end
      if (wr_ctl_b) begin
        if (modulator_enable) begin
          // Channel mode is frozen while running
          ctl_b <= {wdata[7:6], ctl_b[`CTL_B_INDEP_BIT], wdata[4:0]}; // R13
        end else begin
          ctl_b <= wdata;
        end
      end
      if (wr_db && !modulator_enable) begin
        deadband_count <= wdata; // R18
      end
      if (wr_mpw && !modulator_enable) begin
        min_pulse_width <= wdata; // R18
      end
      if (wr_off) begin
        output_off_select <= wdata[5:0];
      end
      if (wr_source) begin
        count_source <= wdata[0];
      end
      if (wr_period) begin
        period_hold <= wdata;
      end
      if (wr_duty) begin
        duty_hold[addr[2:0]] <= wdata;
      end
    end
  end

  // Reload flag: a reload in the clearing cycle wins
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reload_flag <= 1'b0;
    end else if (reload) begin
      reload_flag <= 1'b1; // R21
    end else if (wr_status && wdata[`STATUS_RELOAD_BIT]) begin
      reload_flag <= 1'b0; // R21
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Working registers

  // Stopped: follow holding values; running: copy at a ready reload, reload rate at every period end
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      period_work <= `RST_PERIOD;
      clock_divider_work <= 2'h0;
      rate_work <= 2'h0;
      for (j = 0; j < 6; j = j + 1) begin
        duty_work[j] <= `RST_DUTY;
      end
    end else begin
      if (!modulator_enable || (reload && ready)) begin // R7
        period_work <= period_hold; // R8
        clock_divider_work <= clock_divider; // R16
        for (j = 0; j < 6; j = j + 1) begin
          duty_work[j] <= duty_hold[j]; // R8
        end
      end
      if (!modulator_enable || period_end) begin
        rate_work <= reload_rate; // R11
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master counter

  // External count input synchroniser and edge stage
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else begin
      ext_s1 <= external_count_input;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  // Prescaler, period counter and up/down master counter
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pre_cnt <= 3'h0;
      rate_cnt <= 3'h0;
      cnt <= 8'h00;
      count_up <= 1'b1;
    end else if (!modulator_enable) begin
      pre_cnt <= 3'h0; // R9
      rate_cnt <= 3'h0;
      cnt <= 8'h00; // R9
      count_up <= 1'b1;
    end else begin
      if (base_tick) begin
        pre_cnt <= (pre_cnt == pre_max) ? 3'h0 : pre_cnt + 3'h1; // R15
      end
      if (period_end) begin
        rate_cnt <= reload ? 3'h0 : rate_cnt + 3'h1; // R12
      end
      if (tick) begin
        if (period_end) begin
          cnt <= 8'h00; // R10
          count_up <= 1'b1;
        end else if (align) begin
          if (count_up && (cnt >= period_work)) begin
            count_up <= 1'b0; // R4
            cnt <= cnt - 8'h01;
          end else if (count_up) begin
            cnt <= cnt + 8'h01;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end else begin
          cnt <= cnt + 8'h01;
        end
      end
    end
  end

  // Modulator pin ownership
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mod_ctl <= 1'b0;
    end else if (!outputs_off_ctl) begin
      mod_ctl <= 1'b0; // R1
    end else if (reload) begin
      mod_ctl <= 1'b1; // R2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output shaping

  // Clamp a duty so neither the on nor the off part is below the minimum
  function [7:0] shape_duty;
    input [7:0] d;
    input [7:0] p;
    input [7:0] m;
    begin
      if ((d != 8'h00) && (d < m)) begin
        shape_duty = 8'h00;
      end else if ((d < p) && ((p - d) < m)) begin
        shape_duty = p;
      end else begin
        shape_duty = d;
      end
    end
  endfunction

  // Outputs may follow the modulator only with all gates open
  wire active = modulator_enable && mod_ctl && outputs_off_ctl; // R1

  genvar k;
  generate
    for (k = 0; k < 3; k = k + 1) begin : pair
      reg prev_h;
      reg [7:0] db_cnt;
      wire [7:0] duty_h = shape_duty(duty_work[2*k], period_work, min_pulse_width); // R22
      wire [7:0] duty_l = shape_duty(duty_work[2*k+1], period_work, min_pulse_width); // R19
      wire raw_h = cnt < duty_h;
      wire raw_l = cnt < duty_l;
      // Both sides low from a change of the high side until the count runs out
      wire hold = ((raw_h != prev_h) && (deadband_count != 8'h00)) || (db_cnt != 8'h00); // R17
      wire comp_h = raw_h && !hold;
      wire comp_l = !raw_h && !hold;
      wire drive_h = independent_channels ? raw_h : comp_h; // R13
      wire drive_l = independent_channels ? raw_l : comp_l; // R13
      wire off_h = selective_off_ctl && output_off_select[2*k]; // R3
      wire off_l = selective_off_ctl && output_off_select[2*k+1]; // R20

      // Deadband timer counted in prescaled ticks
      always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          prev_h <= 1'b0;
          db_cnt <= 8'h00;
        end else if (!modulator_enable) begin
          prev_h <= 1'b0;
          db_cnt <= 8'h00;
        end else if (raw_h != prev_h) begin
          prev_h <= raw_h;
          db_cnt <= deadband_count; // R22
        end else if (tick && (db_cnt != 8'h00)) begin
          db_cnt <= db_cnt - 8'h01;
        end
      end

      // Off-state is a low pin; polarity applies to modulated drive only
      assign next_out[2*k] = (active && !off_h) ? (drive_h ^ pair_invert[k]) : 1'b0; // R14
      assign next_out[2*k+1] = (active && !off_l) ? (drive_l ^ pair_invert[k]) : 1'b0; // R14
    end
  endgenerate

  // Pin drive, output enables and converter trigger
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pwm_out <= 6'h00;
      pwm_out_en <= 1'b0;
      converter_trigger <= 1'b0;
    end else begin
      pwm_out <= next_out; // R9
      pwm_out_en <= modulator_enable; // R10
      converter_trigger <= converter_trigger_en && period_end; // R5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads

  // Read mux; buffered fields return their holding value
  always @* begin
    next_rdata = 8'h00;
    if (duty_hit) begin
      next_rdata = duty_hold[addr[2:0]];
    end else begin
      case (addr)
        `ADDR_CTL_A: next_rdata = ctl_a;
        `ADDR_CTL_B: next_rdata = ctl_b; // R11
        `ADDR_DEADBAND: next_rdata = deadband_count;
        `ADDR_MIN_PULSE: next_rdata = min_pulse_width;
        `ADDR_STATUS: next_rdata = {reload_flag, 7'h00};
        `ADDR_OFF_SELECT: next_rdata = {2'h0, output_off_select};
        `ADDR_PERIOD: next_rdata = period_hold;
        `ADDR_COUNT_SOURCE: next_rdata = {7'h00, count_source};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else if (rd_strobe) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// [tb/motor_pwm_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module motor_pwm_chk (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [11:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic [7:0] rdata,
  input wire logic external_count_input,
  input wire logic [5:0] pwm_out,
  input wire logic pwm_out_en,
  input wire logic converter_trigger
);
  logic [7:0] sh_a;
  logic [7:0] sh_b;
  logic [7:0] sh_db;
  logic [7:0] sh_mp;
  logic [5:0] sh_os;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////
  // Shadow copies of control, deadband, min width and off-select registers, rebuilt from bus writes
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sh_a <= 8'h00;
      sh_b <= 8'h00;
      sh_db <= 8'h01;
      sh_mp <= 8'h00;
      sh_os <= 6'h00;
    end else if (wr_strobe) begin
      if (addr == 12'hf20) sh_a <= wdata & 8'heb;
      if (addr == 12'hf21) sh_b <= sh_a[0] ? {wdata[7:6], sh_b[5], wdata[4:0]} : wdata;
      if (addr == 12'hf22 && !sh_a[0]) sh_db <= wdata;
      if (addr == 12'hf23 && !sh_a[0]) sh_mp <= wdata;
      if (addr == 12'hf27) sh_os <= wdata[5:0];
    end
  end
  ////////////////////////////////////////////////////////////
  // Register read of one address
  sequence s_rd(logic [11:0] a);
    rd_strobe && addr == a;
  endsequence
  a_ctl_a_back: assert property (s_rd(12'hf20) |=> rdata == $past(sh_a))
    else $error("control a readback wrong");
  a_ctl_b_back: assert property (s_rd(12'hf21) |=> rdata == $past(sh_b))
    else $error("control b readback wrong");
  a_deadband_lock: assert property (s_rd(12'hf22) |=> rdata == $past(sh_db))
    else $error("deadband readback wrong");
  a_min_width_lock: assert property (s_rd(12'hf23) |=> rdata == $past(sh_mp))
    else $error("min width readback wrong");
  a_en_follow: assert property (pwm_out_en == $past(sh_a[0]))
    else $error("output enable mismatch");
  a_disable_off: assert property (!pwm_out_en |-> pwm_out == 6'h00)
    else $error("pins driven while disabled");
  a_off_now: assert property (!$past(sh_a[7]) |-> pwm_out == 6'h00)
    else $error("pins on while outputs off");
  a_select_off: assert property ($past(sh_a[6]) |-> (pwm_out & $past(sh_os)) == 6'h00)
    else $error("selected pin not off");
  a_trig_gate: assert property (converter_trigger |-> $past(sh_a[3]) && $past(sh_a[0]))
    else $error("trigger while not enabled");
endmodule
bind motor_pwm_control_regs motor_pwm_chk motor_pwm_chk_i (.clk_sys(clk_sys),
  .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
  .rd_strobe(rd_strobe), .rdata(rdata), .external_count_input(external_count_input),
  .pwm_out(pwm_out), .pwm_out_en(pwm_out_en), .converter_trigger(converter_trigger));
`default_nettype wire

// [tb/gate_driver_model.sv]
`timescale 1ns/10ps
`default_nettype none
module gate_driver_model (
  input wire logic clk_sys,
  input wire logic [5:0] pwm_out,
  input wire logic pwm_out_en,
  output logic [5:0] gate_on,
  output logic [5:0] rise
);
  logic [5:0] last;
  // A gate conducts only while the pins are enabled as outputs
  assign gate_on = pwm_out_en ? pwm_out : 6'h00;
  // Previous gate state, to mark each turn-on
  always_ff @(posedge clk_sys) begin
    last <= gate_on;
  end
  assign rise = gate_on & ~last;
endmodule
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk_sys;
  logic reset_n;
  logic [11:0] addr;
  logic [7:0] wdata;
  logic wr_strobe;
  logic rd_strobe;
  logic external_count_input = 1'b0;
  logic [2:0] ext_cnt = 3'h0;
  wire [7:0] rdata;
  wire [5:0] pwm_out;
  wire pwm_out_en;
  wire converter_trigger;
  wire [5:0] gate_on;
  wire [5:0] rise;
  logic [7:0] exp_q[$];
  logic rd_q = 1'b0;
  logic [7:0] rv;
  int err_count;
  int checks_done;
  int ri, hi, lo, ti, sc;
  motor_pwm_control_regs motor_pwm_control_regs_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
    .external_count_input(external_count_input), .pwm_out(pwm_out), .pwm_out_en(pwm_out_en),
    .converter_trigger(converter_trigger));
  gate_driver_model gate_driver_model_i (.clk_sys(clk_sys), .pwm_out(pwm_out),
    .pwm_out_en(pwm_out_en), .gate_on(gate_on), .rise(rise));
  ////////////////////////////////////////////////////////////
  // System clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // External count pin rises every eight system clocks
  always @(posedge clk_sys) begin
    ext_cnt <= ext_cnt + 3'h1;
    external_count_input <= ext_cnt[2];
  end
  // Oldest noted read value meets the data of the cycle after the read
  always @(posedge clk_sys) begin
    if (rd_q === 1'b1)
      chk_rd(rdata, exp_q.pop_front());
    rd_q <= rd_strobe;
  end
  ////////////////////////////////////////////////////////////
  task automatic fail(input string m);
    err_count++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
      fail($sformatf("read %h not %h", got, exp));
  endtask
  task automatic chk_n(input int got, input int exp, input string what);
    checks_done++;
    if (got != exp)
      fail($sformatf("%s %0d not %0d", what, got, exp));
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_strobe <= 1'b1;
    @(posedge clk_sys);
    wr_strobe <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clk_sys);
    rd_strobe <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Counts turn-ons and high cycles of pin 0, high cycles of pin 1, and trigger pulses
  task automatic run(input int n);
    ri = 0;
    hi = 0;
    lo = 0;
    ti = 0;
    repeat (n) begin
      @(posedge clk_sys);
      ri += (rise[0] === 1'b1);
      hi += (gate_on[0] === 1'b1);
      lo += (gate_on[1] === 1'b1);
      ti += (converter_trigger === 1'b1);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Run time limit
  initial begin
    #200000;
    fail("time limit");
    end_of_test();
  end
  // Main sequence
  initial begin
    reset_n = 1'b0;
    addr = 12'h000;
    wdata = 8'h00;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    err_count = 0;
    checks_done = 0;
    rv = 8'($urandom(16));
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    rd(12'hf20, 8'h00);
    rd(12'hf21, 8'h00);
    rd(12'hf22, 8'h01);
    rd(12'hf23, 8'h00);
    rd(12'hf25, 8'h00);
    wr(12'hf2f, 8'h5a);
    rd(12'hf2f, 8'h00);
    wr(12'hf20, 8'heb);
    rd(12'hf20, 8'heb);
    $display("test reset values done");
    // Writes while running are refused where locked
    wr(12'hf20, 8'h01);
    rv = 8'($urandom);
    wr(12'hf22, rv);
    wr(12'hf23, ~rv);
    wr(12'hf21, 8'hff);
    rd(12'hf22, 8'h01);
    rd(12'hf23, 8'h00);
    rd(12'hf21, 8'hdf);
    wr(12'hf20, 8'h00);
    wr(12'hf22, rv);
    wr(12'hf23, ~rv);
    rd(12'hf22, rv);
    rd(12'hf23, ~rv);
    wr(12'hf23, 8'h00);
    $display("test register locks done");
    // Divider codes, external source and pair 0 inversion
    wr(12'hf38, 8'h04);
    wr(12'hf30, 8'h01);
    for (int c = 4; c >= 0; c--) begin
      sc = (c == 4) ? 8 : (1 << c);
      wr(12'hf20, 8'h00);
      wr(12'hf21, {2'b00, 1'b1, 2'b00, c[0], c[1:0]});
      wr(12'hf39, {7'h00, c == 4});
      wr(12'hf20, 8'h8b);
      run(96);
      run(32 * sc);
      chk_n(ri, 8, "rises");
      chk_n(hi, (c[0] ? 24 : 8) * sc, "high");
      chk_n(ti, 8, "triggers");
    end
    $display("test divider done");
    // Holding values wait for the ready bit
    wr(12'hf20, 8'h89);
    wr(12'hf38, 8'h08);
    run(64);
    chk_n(ri, 16, "held period");
    wr(12'hf20, 8'h8b);
    run(40);
    run(64);
    chk_n(ri, 8, "new period");
    $display("test ready done");
    // Off controls, selective off and trigger enable
    wr(12'hf20, 8'h0b);
    run(32);
    chk_n(hi, 0, "off high");
    wr(12'hf20, 8'h8b);
    run(16);
    run(64);
    chk_n(hi, 8, "restored high");
    wr(12'hf27, 8'h01);
    wr(12'hf20, 8'hcb);
    run(64);
    chk_n(hi, 0, "selected high");
    chk_n(ti, 8, "triggers");
    wr(12'hf20, 8'hc3);
    run(64);
    chk_n(ti, 0, "quiet triggers");
    rd(12'hf25, 8'h80);
    wr(12'hf20, 8'h00);
    wr(12'hf25, 8'h80);
    rd(12'hf25, 8'h00);
    $display("test off controls done");
    // Complementary pair 0 with one tick of deadband
    wr(12'hf21, 8'h00);
    wr(12'hf22, 8'h01);
    wr(12'hf30, 8'h03);
    wr(12'hf20, 8'h8b);
    run(40);
    run(64);
    chk_n(hi, 8, "pair high");
    chk_n(lo, 24, "pair low");
    // Center alignment, independent channels
    wr(12'hf20, 8'h00);
    wr(12'hf21, 8'h20);
    wr(12'hf38, 8'h04);
    wr(12'hf20, 8'hab);
    run(40);
    run(64);
    chk_n(hi, 40, "center high");
    chk_n(ti, 8, "center triggers");
    // Minimum pulse filter drops short pulses and fills short gaps
    wr(12'hf20, 8'h00);
    wr(12'hf23, 8'h02);
    wr(12'hf38, 8'h08);
    wr(12'hf30, 8'h01);
    wr(12'hf31, 8'h07);
    wr(12'hf20, 8'h8b);
    run(40);
    run(64);
    chk_n(hi, 0, "short pulse");
    chk_n(lo, 64, "short gap");
    wr(12'hf20, 8'h00);
    $display("test waveform shapes done");
    end_of_test();
  end
endmodule
`default_nettype wire
